/* File: dv/lcam_nbr_model.sv */
// Neighbouring cell model that feeds the chain inputs of the cell
`timescale 1ns/100ps
module lcam_nbr_model (
  input logic ref_clk,
  input logic reset_n,
  input logic cyReq,
  input logic shReq,
  input logic slow,
  output logic carryIn,
  output logic sharedIn
);
  logic [1:0] cyPipe;
  logic [1:0] shPipe;
  // ----------------------------------------
  // Chain outputs
  // ----------------------------------------
  // Registered like a real cell; slow adds one stage of chain latency
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyPipe <= 2'h0;
      shPipe <= 2'h0;
    end else begin
      cyPipe <= {cyPipe[0], cyReq};
      shPipe <= {shPipe[0], shReq};
    end
  end
  assign carryIn = slow ? cyPipe[1] : cyPipe[0];
  assign sharedIn = slow ? shPipe[1] : shPipe[0];
endmodule

/* File: dv/tb_logic_cell_arithmetic_modes.sv */
// Self-checking bench of the logic cell against a behavioural model
`timescale 1ns/100ps
module tb_logic_cell_arithmetic_modes;
  logic ref_clk, reset_n, busWrStb, busRdStb, cyReq, shReq, slow;
  logic in_a, in_b, in_c, in_d, in_e0, in_e1, in_f0, in_f1;
  logic clusterClkEn, localClkEn, localCntEn, localUpDown, localAddSub;
  logic clusterSyncClr, clusterSyncLoad, carryIn, sharedIn, carryOut, sharedOut, carryTap;
  logic [1:0] clusterClr;
  logic [3:0] busAddr, cellOut, mQ, mO;
  logic [15:0] busWrData, busRdData, rd2, mode, fc, last2;
  logic [15:0] mask [8];
  logic mCy, mSh, mTap;
  int n_errors, checks;

  lcam_cell dut (.*);
  lcam_cell #(.CELL_INDEX(2)) dut2 (.*, .busRdData(rd2), .cellOut(), .carryOut(),
    .sharedOut(), .carryTap());
  lcam_nbr_model nbr (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Behavioural model
  // ----------------------------------------
  function automatic logic [10:0] calc();
    logic [3:0] lo, hi, ld, d, q;
    logic [6:0] idx;
    logic [1:0] s0, s1;
    logic w0, w1, w2, w3, fn, cnt, inv, cin, sIn, cy, sh;
    lo = {in_f0, in_c, in_b, in_a};
    hi = {in_f1, in_e1, in_e0, in_d};
    ld = {in_d, in_c, in_b, in_a};
    idx = {mode[2] ? in_f1 : in_f0, hi[2:0], lo[2:0]};
    fn = mask[idx[6:4]][idx[3:0]];
    cnt = mode[8] && mode[1:0] == 2'h1;
    w0 = cnt ? mQ[0] : mask[0][lo];
    w1 = cnt ? 1'b0 : mask[1][lo];
    w2 = cnt ? mQ[1] : mask[2][hi];
    w3 = cnt ? 1'b0 : mask[3][hi];
    inv = cnt ? !localUpDown : localAddSub;
    cin = !mode[4] ? carryIn : (mode[1:0] == 2'h2) ? 1'b0 : cnt ? localUpDown : localAddSub;
    sIn = mode[5] ? 1'b0 : sharedIn;
    if (mode[1:0] == 2'h2) begin
      s0 = w0 + sIn + cin;
      s1 = w2 + w1 + s0[1];
    end else begin
      s0 = w0 + (w1 ^ inv) + cin;
      s1 = w2 + (w3 ^ inv) + s0[1];
    end
    d = mode[3] ? {w2, w0, w2, w0} : {s1[0], s0[0], s1[0], s0[0]};
    if (mode[1:0] == 2'h0) d = mode[2] ? {fn, fn, in_f0, in_f0} : {in_f1, in_f1, fn, fn};
    if (mode[1:0] == 2'h3) d = 4'h0;
    cy = mode[6] ? carryIn : (mode[1:0] == 2'h1 || mode[1:0] == 2'h2) ? s1[1] : 1'b0;
    sh = mode[6] ? sharedIn : (mode[1:0] == 2'h2) ? w3 : 1'b0;
    q = mQ;
    for (int k = 0; k < 4; k++) begin
      if (clusterClr[fc[12 + k]]) q[k] = 1'b0;
      else if (clusterClkEn && localClkEn) begin
        if (fc[4 + k] && clusterSyncClr) q[k] = 1'b0;
        else if (fc[8 + k] && clusterSyncLoad) q[k] = ld[k];
        else if (!(cnt && k < 2 && !localCntEn)) q[k] = d[k];
      end
    end
    d = (fc[3:0] & d) | (~fc[3:0] & q);
    return {mode[7] & carryIn, sh, cy, d, q};
  endfunction

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) {mTap, mSh, mCy, mO, mQ} <= 11'h000;
    else {mTap, mSh, mCy, mO, mQ} <= calc();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] e, logic [15:0] got);
    checks++;
    if (got !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge ref_clk);
    busAddr <= a;
    busWrData <= d;
    busWrStb <= 1'b1;
    @(posedge ref_clk);
    busWrStb <= 1'b0;
    if (a == 4'h0) mode <= d;
    if (a == 4'h1) fc <= d;
    if (a[3]) mask[a[2:0]] <= d;
  endtask

  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge ref_clk);
    busAddr <= a;
    busRdStb <= 1'b1;
    @(posedge ref_clk);
    busRdStb <= 1'b0;
    @(negedge ref_clk);
    last2 = rd2;
    chk("busRdData", e, busRdData);
    @(negedge ref_clk);
    chk("busRdIdle", 16'h0000, busRdData);
  endtask

  // Controls come from c, bits set in rm are random; data is random unless rm is zero
  task automatic go(int n, logic [8:0] c, logic [8:0] rm);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      {clusterClr, clusterSyncLoad, clusterSyncClr, localAddSub, localUpDown, localCntEn,
        localClkEn, clusterClkEn} <= (c & ~rm) | (9'($urandom) & rm);
      if (rm != 9'h000) begin
        {in_f1, in_f0, in_e1, in_e0, in_d, in_c, in_b, in_a} <= 8'($urandom);
        {slow, shReq, cyReq} <= 3'($urandom);
      end
      @(negedge ref_clk);
      chk("cellOut", {12'h000, mO}, {12'h000, cellOut});
      chk("carryTap", 16'(mTap), 16'(carryTap));
      chk("carryOut", 16'(mCy), 16'(carryOut));
      chk("sharedOut", 16'(mSh), 16'(sharedOut));
    end
  endtask

  task automatic complete_run();
    $display("Errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {busWrStb, busRdStb, cyReq, shReq, slow, busAddr, busWrData} = '0;
    {in_f1, in_f0, in_e1, in_e0, in_d, in_c, in_b, in_a} = '0;
    {clusterClr, clusterSyncLoad, clusterSyncClr, localAddSub, localUpDown, localCntEn,
      localClkEn, clusterClkEn} = '0;
    mode = 16'h0000;
    fc = 16'h0000;
    foreach (mask[i]) mask[i] = 16'h0000;
    n_errors = 0;
    checks = 0;
    reset_n = 1'b0;
    void'($urandom(32'he14f_4a15));
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 3; a++) rd(4'(a), 16'h0000);
    wr(4'h3, 16'hffff);
    rd(4'h3, 16'h0000);
    for (int w = 8; w < 16; w++) wr(4'(w), 16'($urandom));
    wr(4'h1, 16'h000b);
    wr(4'h0, 16'h0000);
    go(40, 9'h003, 9'h010);
    go(20, 9'h000, 9'h010);
    rd(4'h9, mask[1]);
    wr(4'h0, 16'h0004);
    rd(4'h0, 16'h0004);
    go(40, 9'h003, 9'h010);
    wr(4'h0, 16'h0011);
    go(40, 9'h003, 9'h010);
    wr(4'h0, 16'h0001);
    go(40, 9'h003, 9'h010);
    wr(4'h0, 16'h0019);
    go(30, 9'h003, 9'h010);
    wr(4'h0, 16'h00c1);
    go(30, 9'h003, 9'h010);
    wr(4'h1, 16'h5ff0);
    wr(4'h0, 16'h0011);
    go(60, 9'h003, 9'h1e3);
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0111);
    go(50, 9'h003, 9'h00c);
    wr(4'h0, 16'h0002);
    go(40, 9'h003, 9'h010);
    wr(4'h0, 16'h0032);
    go(30, 9'h003, 9'h010);
    wr(4'h2, 16'h00ff);
    wr(4'h0, 16'h0031);
    go(4, 9'h003, 9'h000);
    rd(4'h2, {9'h000, mTap, mSh, mCy, mQ});
    chk("startRefused", 16'h0001, 16'(last2[7]));
    wr(4'h0, 16'h0003);
    go(5, 9'h003, 9'h010);
    complete_run();
  end

  // Cuts a hang short well beyond the length of the sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    complete_run();
  end
endmodule

/* File: include/lcam_params.svh */
// Constants, offsets and field positions of the logic cell
// Functional notes
// - Extended mode forms one seven-input function from a..e1 plus f0 or f1.
// - With f0 selecting, result feeds flop0/flop1; in_f1 packs into flop2/flop3.
// - With f1 selecting, result feeds flop2/flop3; in_f0 packs into flop0/flop1.
// - Arithmetic mode: four 4-input tables feeding two full adders.
// - Carry-only use: adder carry kept, sum dropped for table outputs.
// - Arithmetic controls: clock enable, count enable, direction, add/sub, clear, load.
// - Enable, count, direction and add/sub come from cluster local inputs.
// - Cluster sync clear and load reach all flops, each individually enabled.
// - Carry chain may start only at cluster cell one or five.
// - Upper-half chains continue into next upper half, lower into lower.
// - Final carry-out enters a cell and drives general routing.
// - Long chains link successive clusters vertically up to a column.
// - Shared mode: tables give three-input sum or carry, carry on shared chain.
// - Shared chain may start only at cluster cell one or six.
// - Ordinary clusters bypass the lower half, memory clusters the upper.
// - Cluster clock is tied to its enable; low enable freezes the flops. Here a selected cluster clear still zeroes a flop while the enable is low.
// - Each flop has a cluster clear, two clears per cluster.
`ifndef LCAM_PARAMS_SVH
`define LCAM_PARAMS_SVH
// ----------------------------------------
// Register bus
// ----------------------------------------
`define LCAM_ADDR_W 4
`define LCAM_DATA_W 16
`define LCAM_REG_MODE 4'h0
`define LCAM_REG_FLOP 4'h1
`define LCAM_REG_STATUS 4'h2
`define LCAM_LUT_SEL_BIT 3
`define LCAM_LUT_WORDS 8
`define LCAM_MODE_RST 16'h0000
`define LCAM_FLOP_RST 16'h0000
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define LCAM_MODE_LSB 0
`define LCAM_EXT_F1 2
`define LCAM_CARRY_ONLY 3
`define LCAM_CARRY_START 4
`define LCAM_SHARED_START 5
`define LCAM_HALF_BYPASS 6
`define LCAM_CARRY_TAP 7
`define LCAM_COUNTER 8
// ----------------------------------------
// Flop register fields
// ----------------------------------------
`define LCAM_BYPASS_LSB 0
`define LCAM_SCLR_LSB 4
`define LCAM_SLOAD_LSB 8
`define LCAM_CLRSEL_LSB 12
// ----------------------------------------
// Cluster geometry
// ----------------------------------------
`define LCAM_CLUSTER_CELLS 10
`define LCAM_HALF_CELLS 5
`define LCAM_CARRY_START_A 0
`define LCAM_CARRY_START_B 4
`define LCAM_SHARED_START_A 0
`define LCAM_SHARED_START_B 5
`define LCAM_CHAIN_CELLS 20
`define LCAM_CHAIN_ARITH_CELLS 10
`endif

/* File: include/lcam_pkg.sv */
// Types of the logic cell
package lcam_pkg;
  typedef enum logic [1:0] {LCAM_EXT, LCAM_ARITH, LCAM_SHARED, LCAM_IDLE} lcam_mode_t;
  typedef struct packed {
    logic [15:0] modeCfg;
    logic [15:0] flopCfg;
    logic [3:0] flopQ;
    logic [3:0] cellOut;
    logic carryOut;
    logic sharedOut;
    logic carryTap;
    logic [15:0] rdData;
  } lcam_state_t;
endpackage

/* File: logic/lcam_cell.sv */
// Logic cell with extended, arithmetic and shared arithmetic modes
`timescale 1ns/100ps
`include "lcam_params.svh"
module lcam_cell #(
  parameter int CELL_INDEX = 0,
  parameter bit MEMORY_CLUSTER = 1'b0
) (
  input logic ref_clk,
  input logic reset_n,
  input logic [`LCAM_ADDR_W-1:0] busAddr,
  input logic [`LCAM_DATA_W-1:0] busWrData,
  input logic busWrStb,
  input logic busRdStb,
  output logic [`LCAM_DATA_W-1:0] busRdData,
  input logic in_a,
  input logic in_b,
  input logic in_c,
  input logic in_d,
  input logic in_e0,
  input logic in_e1,
  input logic in_f0,
  input logic in_f1,
  input logic clusterClkEn,
  input logic localClkEn,
  input logic localCntEn,
  input logic localUpDown,
  input logic localAddSub,
  input logic clusterSyncClr,
  input logic clusterSyncLoad,
  input logic [1:0] clusterClr,
  input logic carryIn,
  input logic sharedIn,
  output logic [3:0] cellOut,
  output logic carryOut,
  output logic sharedOut,
  output logic carryTap
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic lutPick(input logic [15:0] mask, input logic [3:0] idx);
    lutPick = mask[idx];
  endfunction

  function automatic logic [1:0] fullAdd(input logic x, input logic y, input logic ci);
    fullAdd = {(x & y) | (ci & (x ^ y)), x ^ y ^ ci};
  endfunction

  localparam int LUT_WORDS = `LCAM_LUT_WORDS;
  localparam bit CARRY_START_OK =
    (CELL_INDEX == `LCAM_CARRY_START_A) || (CELL_INDEX == `LCAM_CARRY_START_B);
  localparam bit SHARED_START_OK =
    (CELL_INDEX == `LCAM_SHARED_START_A) || (CELL_INDEX == `LCAM_SHARED_START_B);
  localparam bit BYPASSABLE =
    MEMORY_CLUSTER ? (CELL_INDEX >= `LCAM_HALF_CELLS) : (CELL_INDEX < `LCAM_HALF_CELLS);

  lcam_pkg::lcam_state_t st;
  lcam_pkg::lcam_state_t nx;
  lcam_pkg::lcam_mode_t mode;
  logic [LUT_WORDS*16-1:0] maskFlat;
  logic fSel;
  logic lut7;
  logic [3:0] loIdx;
  logic [3:0] hiIdx;
  logic w0;
  logic w1;
  logic w2;
  logic w3;
  logic isArith;
  logic isShared;
  logic counting;
  logic carryOnly;
  logic invB;
  logic carryStartUse;
  logic chainCin;
  logic shIn;
  logic opA0;
  logic opB0;
  logic opA1;
  logic opB1;
  logic [1:0] add0;
  logic [1:0] add1;
  logic halfBypass;
  logic startRefused;
  logic ce;
  logic [3:0] clrHit;
  logic [3:0] dVal;
  logic [3:0] loadVal;
  logic [15:0] rdMux;

  // ----------------------------------------
  // Table masks
  // ----------------------------------------
  lcam_lut_mem #(
    .WORDS(LUT_WORDS),
    .WIDTH(16),
    .AW(3)
  ) uMem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .wrEn(busWrStb && busAddr[`LCAM_LUT_SEL_BIT]),
    .wrAddr(busAddr[2:0]),
    .wrData(busWrData),
    .maskFlat(maskFlat)
  );

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  assign mode = lcam_pkg::lcam_mode_t'(st.modeCfg[`LCAM_MODE_LSB +: 2]);
  assign isArith = (mode == lcam_pkg::LCAM_ARITH);
  assign isShared = (mode == lcam_pkg::LCAM_SHARED);
  assign fSel = st.modeCfg[`LCAM_EXT_F1];
  assign counting = st.modeCfg[`LCAM_COUNTER] && isArith;
  assign carryOnly = st.modeCfg[`LCAM_CARRY_ONLY];
  assign lut7 = maskFlat[{fSel ? in_f1 : in_f0, in_e1, in_e0, in_d, in_c, in_b, in_a}];
  assign loIdx = {in_f0, in_c, in_b, in_a};
  assign hiIdx = {in_f1, in_e1, in_e0, in_d};
  assign w0 = lutPick(maskFlat[15:0], loIdx);
  assign w1 = lutPick(maskFlat[31:16], loIdx);
  assign w2 = lutPick(maskFlat[47:32], hiIdx);
  assign w3 = lutPick(maskFlat[63:48], hiIdx);
  // Direction and add/sub only flip operand B; carry-in supplies the +1
  assign invB = counting ? ~localUpDown : localAddSub;
  assign carryStartUse = st.modeCfg[`LCAM_CARRY_START] && CARRY_START_OK;
  // Start carry is 1 for subtract or up count: the inverted B or the up-count step needs its +1 here
  assign chainCin = carryStartUse ? (isShared ? 1'b0 : invB ^ counting) : carryIn;
  assign shIn = (st.modeCfg[`LCAM_SHARED_START] && SHARED_START_OK) ? 1'b0 : sharedIn;
  assign opA0 = (counting && !isShared) ? st.flopQ[0] : w0;
  assign opA1 = (counting && !isShared) ? st.flopQ[1] : w2;
  assign opB0 = isShared ? shIn : ((counting ? 1'b0 : w1) ^ invB);
  assign opB1 = isShared ? w1 : ((counting ? 1'b0 : w3) ^ invB);
  assign add0 = fullAdd(opA0, opB0, chainCin);
  assign add1 = fullAdd(opA1, opB1, add0[1]);
  assign halfBypass = st.modeCfg[`LCAM_HALF_BYPASS] && BYPASSABLE;
  assign startRefused = (st.modeCfg[`LCAM_CARRY_START] && !CARRY_START_OK) ||
                        (st.modeCfg[`LCAM_SHARED_START] && !SHARED_START_OK);
  assign ce = clusterClkEn && localClkEn;
  assign loadVal = {in_d, in_c, in_b, in_a};
  assign rdMux = busAddr[`LCAM_LUT_SEL_BIT] ? maskFlat[{busAddr[2:0], 4'h0} +: 16] :
                 (busAddr == `LCAM_REG_MODE) ? st.modeCfg :
                 (busAddr == `LCAM_REG_FLOP) ? st.flopCfg :
                 (busAddr == `LCAM_REG_STATUS) ?
                 {8'h00, startRefused, st.carryTap, st.sharedOut, st.carryOut, st.flopQ} :
                 16'h0000;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    dVal = 4'h0;
    clrHit = 4'h0;
    case (mode)
      lcam_pkg::LCAM_EXT: begin
        if (fSel) begin
          dVal = {lut7, lut7, in_f0, in_f0};
        end else begin
          dVal = {in_f1, in_f1, lut7, lut7};
        end
      end
      lcam_pkg::LCAM_ARITH, lcam_pkg::LCAM_SHARED: begin
        // Carry-only use keeps table outputs and drops the sum
        dVal[0] = carryOnly ? w0 : add0[0];
        dVal[1] = carryOnly ? w2 : add1[0];
        dVal[2] = dVal[0];
        dVal[3] = dVal[1];
      end
      default: begin
        dVal = 4'h0;
      end
    endcase
    for (int k = 0; k < 4; k++) begin
      clrHit[k] = clusterClr[st.flopCfg[`LCAM_CLRSEL_LSB + k]];
      // Clear taken at the edge, ahead of the enable, in this one-clock model
      if (clrHit[k]) begin
        nx.flopQ[k] = 1'b0;
      end else if (ce) begin
        if (clusterSyncClr && st.flopCfg[`LCAM_SCLR_LSB + k]) begin
          nx.flopQ[k] = 1'b0;
        end else if (clusterSyncLoad && st.flopCfg[`LCAM_SLOAD_LSB + k]) begin
          nx.flopQ[k] = loadVal[k];
        end else if (!(counting && k < 2 && !localCntEn)) begin
          nx.flopQ[k] = dVal[k];
        end
      end
      nx.cellOut[k] = st.flopCfg[`LCAM_BYPASS_LSB + k] ? dVal[k] : nx.flopQ[k];
    end
    // Outputs are registered, so each cell adds one cycle along a chain
    if (halfBypass) begin
      nx.carryOut = carryIn;
      nx.sharedOut = sharedIn;
    end else if (isArith || isShared) begin
      nx.carryOut = add1[1];
      nx.sharedOut = isShared ? w3 : 1'b0;
    end else begin
      nx.carryOut = 1'b0;
      nx.sharedOut = 1'b0;
    end
    nx.carryTap = st.modeCfg[`LCAM_CARRY_TAP] ? carryIn : 1'b0;
    if (busWrStb && busAddr == `LCAM_REG_MODE) begin
      nx.modeCfg = busWrData;
    end
    if (busWrStb && busAddr == `LCAM_REG_FLOP) begin
      nx.flopCfg = busWrData;
    end
    nx.rdData = busRdStb ? rdMux : 16'h0000;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{modeCfg: `LCAM_MODE_RST, flopCfg: `LCAM_FLOP_RST, default: '0};
    end else begin
      st <= nx;
    end
  end

  assign busRdData = st.rdData;
  assign cellOut = st.cellOut;
  assign carryOut = st.carryOut;
  assign sharedOut = st.sharedOut;
  assign carryTap = st.carryTap;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  logic [2:0] arithRef;
  assign arithRef = 3'({1'b0, w2, w0} + {1'b0, w3 ^ invB, w1 ^ invB} + {2'b00, chainCin});

  sequence s_clr_req;
    ce && clusterSyncClr && st.flopCfg[`LCAM_SCLR_LSB + 1] && !clrHit[1];
  endsequence
  sequence s_clr_seen;
    st.flopQ[1] == 1'b0;
  endsequence

  a_ext_f0_path: assert property (mode == lcam_pkg::LCAM_EXT && !fSel &&
    st.flopCfg[1] && st.flopCfg[3] |=> st.cellOut[1] == $past(lut7) &&
    st.cellOut[3] == $past(in_f1)) else $error("f0 extended path wrong");
  a_ext_f1_path: assert property (mode == lcam_pkg::LCAM_EXT && fSel &&
    st.flopCfg[1] && st.flopCfg[3] |=> st.cellOut[3] == $past(lut7) &&
    st.cellOut[1] == $past(in_f0)) else $error("f1 extended path wrong");
  a_arith_sum_bits: assert property (isArith && !counting && !carryOnly &&
    st.flopCfg[0] && st.flopCfg[1] |=> st.cellOut[1:0] == $past(arithRef[1:0]))
    else $error("arithmetic sum wrong");
  a_arith_carry_out: assert property (isArith && !counting && !halfBypass |=>
    st.carryOut == $past(arithRef[2])) else $error("carry out wrong");
  a_carry_only_path: assert property (isArith && carryOnly && st.flopCfg[0] |=>
    st.cellOut[0] == $past(w0)) else $error("carry-only output wrong");
  a_sync_clear_hit: assert property (s_clr_req |=> s_clr_seen)
    else $error("sync clear missed");
  a_clk_gate_hold: assert property (!ce && clrHit == 4'h0 |=> $stable(st.flopQ))
    else $error("flop moved with enable low");
  a_async_clear_hit: assert property (clrHit[3] |=> !st.flopQ[3] ##1
    (clrHit[3] || ce || st.flopQ[3] == 1'b0)) else $error("cluster clear missed");
  a_half_bypass_pass: assert property (halfBypass |=> st.carryOut == $past(carryIn) &&
    st.sharedOut == $past(sharedIn)) else $error("half bypass broken");
  a_carry_tap_out: assert property (st.modeCfg[`LCAM_CARRY_TAP] |=>
    st.carryTap == $past(carryIn)) else $error("carry tap wrong");
endmodule

/* File: logic/lcam_lut_mem.sv */
// Table mask memory of the logic cell
`timescale 1ns/100ps
module lcam_lut_mem #(
  parameter int WORDS = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input logic ref_clk,
  input logic reset_n,
  input logic wrEn,
  input logic [AW-1:0] wrAddr,
  input logic [WIDTH-1:0] wrData,
  output logic [WORDS*WIDTH-1:0] maskFlat
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Whole array is visible at once, every table reads its mask in parallel
  logic [WORDS*WIDTH-1:0] mem_reg;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_reg <= '0;
    end else if (wrEn) begin
      mem_reg[wrAddr*WIDTH +: WIDTH] <= wrData;
    end
  end
  assign maskFlat = mem_reg;
endmodule
